// ### rtl/rx_test_params.svh
/*
 * Constants of the serial receiver test and mode logic: register offsets,
 * field positions, reset values, code patterns and self-test pattern layout.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef RX_TEST_PARAMS_SVH
`define RX_TEST_PARAMS_SVH

// register byte offsets on the APB
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_ERROR_COUNT 12'h008
`define REG_LOOP_COUNT 12'h00c
`define CONTROL_RESET 32'h0000_0000

// control fields
`define CTRL_FRAMER_OFF 0
`define CTRL_COUNT_CLEAR 1

// status fields
`define STAT_MODE_LO 0
`define STAT_SELF_TEST 2
`define STAT_LOCKED 3
`define STAT_AWAIT_COMMA 4

// 10-bit symbol framing
`define SYMBOL_LAST_BIT 4'h9
`define COMMA_NEG 10'h0fa
`define COMMA_POS 10'h305
`define K28_NEG 6'h0f
`define K28_POS 6'h30

// decoded byte values
`define K28_5_BYTE 8'hbc
`define VIOLATION_BYTE 8'he0

// self-test loop: index 0 carries the start code, these carry violations
`define ST_VIOL_A 8'h40
`define ST_VIOL_B 8'h80
`define ST_VIOL_C 8'hc0
`define ST_DATA_MASK 8'h00

`endif

// ### rtl/rx_test_pkg.sv
/*
 * Types shared by the serial receiver test and mode logic.
 * Assumes the constants header is on the include path.
 */
`include "rx_test_params.svh"

package rx_test_pkg;

	// three-level mode pin, resolved into two logic levels at the pad
	typedef enum logic [1:0]
	{
		MODE_DECODE = 2'b00,
		MODE_TEST_LO = 2'b01,
		MODE_TEST_HI = 2'b10,
		MODE_BYPASS = 2'b11
	} mode_type;

	// self-test checker progress
	typedef enum logic [1:0]
	{
		ST_OFF = 2'b00,
		ST_HUNT = 2'b01,
		ST_RUN = 2'b10
	} self_test_state_type;

	// one decoded character
	typedef struct packed
	{
		logic valid;
		logic special;
		logic [7:0] data;
	} decode_result_type;

	// parallel output group that moves together
	typedef struct packed
	{
		logic [7:0] data;
		logic special;
		logic violation;
	} byte_out_type;

endpackage

// ### rtl/serial_rx_test_modes.sv
/*
 * Receiver framing, decode, bypass, factory test clocking and built-in
 * self-test checker, with an APB status/control slave.
 * Assumes: pll_bit_strobe is a one-cycle pulse on clock per recovered bit;
 * serial, mode, self-test and reframe pins are asynchronous to clock;
 * test_bit_clock_input is slower than a quarter of the clock rate.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_rx_test_modes
	import rx_test_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic serial_data,
	input wire logic pll_bit_strobe,
	input wire logic test_bit_clock_input,
	input wire logic [1:0] mode_level,
	input wire logic self_test_enable_n,
	input wire logic reframe_enable,
	output logic [7:0] decoded_data,
	output logic special_char_flag,
	output logic receive_violation,
	output logic [9:0] raw_symbol_bits,
	output logic ready_n
);
	`include "rx_test_params.svh"

	// pin bundle: serial, test clock, mode[1:0], self-test enable, reframe
	localparam int PINS = 6;
	// reset level of each synchroniser matches its pin at rest; only the
	// active-low self-test enable idles high, so reset never fakes an entry
	localparam logic [PINS-1:0] PIN_IDLE = 6'b000010;
	logic [PINS-1:0] pin_raw;
	logic [PINS-1:0] pin_meta;
	logic [PINS-1:0] pin_sync;

	assign pin_raw = {serial_data, test_bit_clock_input, mode_level,
		self_test_enable_n, reframe_enable};

	// two-stage synchronisers, the first stage feeds only the second
	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1)
		begin : sync_gen
			always_ff @(posedge clock or negedge reset_n)
			begin
				if (!reset_n)
				begin
					pin_meta[g] <= PIN_IDLE[g];
					pin_sync[g] <= PIN_IDLE[g];
				end
				else
				begin
					pin_meta[g] <= pin_raw[g];
					pin_sync[g] <= pin_meta[g];
				end
			end
		end
	endgenerate

	logic rx_bit;
	logic test_clk_s;
	mode_type mode;
	logic st_enable;
	logic rf_s;
	assign rx_bit = pin_sync[5];
	assign test_clk_s = pin_sync[4];
	assign mode = mode_type'(pin_sync[3:2]);
	assign st_enable = ~pin_sync[1]; // active-low pin
	assign rf_s = pin_sync[0];

	// decode a 10-bit symbol held as {a,b,c,d,e,i,f,g,h,j}
	function automatic decode_result_type decode_symbol(input logic [9:0] sym);
		logic [5:0] six;
		logic [3:0] four;
		logic [4:0] lo;
		logic [2:0] hi;
		logic ok6;
		logic ok4;
		logic k28;
		decode_result_type r;
		six = sym[9:4];
		four = sym[3:0];
		lo = 5'h00;
		hi = 3'h0;
		ok6 = 1'b1;
		ok4 = 1'b1;
		k28 = (six == `K28_NEG) || (six == `K28_POS);
		// data bits A..E from abcdei, i carries no data of its own
		case (six)
			6'h27, 6'h18: lo = 5'd0;
			6'h1d, 6'h22: lo = 5'd1;
			6'h2d, 6'h12: lo = 5'd2;
			6'h31: lo = 5'd3;
			6'h35, 6'h0a: lo = 5'd4;
			6'h29: lo = 5'd5;
			6'h19: lo = 5'd6;
			6'h38, 6'h07: lo = 5'd7;
			6'h39, 6'h06: lo = 5'd8;
			6'h25: lo = 5'd9;
			6'h15: lo = 5'd10;
			6'h34: lo = 5'd11;
			6'h0d: lo = 5'd12;
			6'h2c: lo = 5'd13;
			6'h1c: lo = 5'd14;
			6'h17, 6'h28: lo = 5'd15;
			6'h1b, 6'h24: lo = 5'd16;
			6'h23: lo = 5'd17;
			6'h13: lo = 5'd18;
			6'h32: lo = 5'd19;
			6'h0b: lo = 5'd20;
			6'h2a: lo = 5'd21;
			6'h1a: lo = 5'd22;
			6'h3a, 6'h05: lo = 5'd23;
			6'h33, 6'h0c: lo = 5'd24;
			6'h26: lo = 5'd25;
			6'h16: lo = 5'd26;
			6'h36, 6'h09: lo = 5'd27;
			6'h0e, 6'h0f, 6'h30: lo = 5'd28;
			6'h2e, 6'h11: lo = 5'd29;
			6'h1e, 6'h21: lo = 5'd30;
			6'h2b, 6'h14: lo = 5'd31;
			default: ok6 = 1'b0;
		endcase
		// positive-disparity special forms use the complemented fghj
		if (six == `K28_POS)
			four = ~four;
		// data bits F..H from fghj, j carries no data of its own
		case (four)
			4'hb, 4'h4: hi = 3'd0;
			4'h9: hi = 3'd1;
			4'h5: hi = 3'd2;
			4'hc, 4'h3: hi = 3'd3;
			4'hd, 4'h2: hi = 3'd4;
			4'ha: hi = 3'd5;
			4'h6: hi = 3'd6;
			4'he, 4'h1, 4'h7, 4'h8: hi = 3'd7;
			default: ok4 = 1'b0;
		endcase
		r.valid = ok6 && ok4;
		r.special = k28 && r.valid;
		r.data = {hi, lo};
		if (!r.valid)
		begin
			r.special = 1'b1;
			r.data = `VIOLATION_BYTE;
		end
		return r;
	endfunction

	// expected self-test character at a loop index
	function automatic byte_out_type expected_at(input logic [7:0] idx);
		byte_out_type e;
		e.data = idx ^ `ST_DATA_MASK;
		e.special = 1'b0;
		e.violation = 1'b0;
		if (idx == 8'h00)
		begin
			e.data = `K28_5_BYTE;
			e.special = 1'b1;
		end
		else if (idx == `ST_VIOL_A || idx == `ST_VIOL_B || idx == `ST_VIOL_C)
		begin
			e.data = `VIOLATION_BYTE;
			e.special = 1'b1;
			e.violation = 1'b1;
		end
		return e;
	endfunction

	// register file and APB state
	logic [31:0] control;
	logic [31:0] next_control;
	logic [15:0] error_count;
	logic [15:0] next_error_count;
	logic [15:0] loop_count;
	logic [15:0] next_loop_count;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic count_clear;

	// receive path state
	logic test_clk_d; // previous test clock level, for edge detect
	logic [9:0] shifter;
	logic [9:0] next_shifter;
	logic [3:0] bit_count;
	logic [3:0] next_bit_count;
	logic rf_d;
	logic await_comma;
	logic next_await_comma;
	logic last_was_comma;
	logic next_last_was_comma;
	self_test_state_type st_state;
	self_test_state_type next_st_state;
	logic [7:0] st_index;
	logic [7:0] next_st_index;
	byte_out_type outs;
	byte_out_type next_outs;
	logic [9:0] next_raw;
	logic next_ready_n;

	logic test_mode;
	logic bit_strobe;
	logic framer_allowed;
	logic comma_hit;
	logic char_done;
	decode_result_type dec;
	byte_out_type expect_now;
	logic mismatch;

	// an open pin resolves to either middle code
	assign test_mode = (mode == MODE_TEST_LO) || (mode == MODE_TEST_HI);
	// factory test replaces the recovered bit timing with the tester's clock
	assign bit_strobe = test_mode ? (test_clk_s && !test_clk_d) : pll_bit_strobe;
	assign framer_allowed = rf_s && !control[`CTRL_FRAMER_OFF];
	assign comma_hit = framer_allowed &&
		((next_shifter == `COMMA_NEG) || (next_shifter == `COMMA_POS));
	assign char_done = bit_strobe &&
		((bit_count == `SYMBOL_LAST_BIT) || comma_hit);
	assign dec = decode_symbol(next_shifter);
	assign expect_now = expected_at(st_index);
	assign mismatch = (dec.data != expect_now.data) ||
		(dec.special != expect_now.special) ||
		(dec.valid == expect_now.violation);

	// framer, self-test checker and output selection
	always_comb
	begin
		next_shifter = shifter;
		next_bit_count = bit_count;
		next_await_comma = await_comma;
		next_last_was_comma = last_was_comma;
		next_st_state = st_state;
		next_st_index = st_index;
		next_outs = outs;
		next_raw = raw_symbol_bits;
		next_ready_n = 1'b1;
		next_loop_count = loop_count;
		next_error_count = error_count;
		if (count_clear)
		begin
			next_loop_count = 16'h0000;
			next_error_count = 16'h0000;
		end
		if (bit_strobe)
			next_shifter = {shifter[8:0], rx_bit};
		if (!st_enable)
			next_st_state = ST_OFF;
		else if (st_state == ST_OFF)
			next_st_state = ST_HUNT;
		if (st_state != ST_OFF && st_enable)
			next_ready_n = (st_state == ST_HUNT);
		if (bit_strobe)
			next_bit_count = char_done ? 4'h0 : bit_count + 4'h1;
		if (char_done)
		begin
			if (comma_hit)
				next_await_comma = 1'b0;
			next_last_was_comma = dec.special && (dec.data == `K28_5_BYTE);
			if (st_state == ST_HUNT && st_enable)
			begin
				// violations seen before the start code still show
				next_outs = '{data: dec.data, special: dec.special,
					violation: !dec.valid};
				if (dec.special && dec.data == `K28_5_BYTE)
				begin
					next_st_state = ST_RUN;
					next_st_index = 8'h01;
					next_ready_n = 1'b0;
				end
			end
			else if (st_state == ST_RUN && st_enable)
			begin
				// same checking for bypass, decode and factory test
				next_outs = '{data: expect_now.data, special: expect_now.special,
					violation: mismatch};
				next_st_index = st_index + 8'h01;
				next_ready_n = (st_index == 8'h00);
				if (st_index == 8'h00)
					next_loop_count = next_loop_count + 16'h0001;
				if (mismatch && error_count != 16'hffff)
					next_error_count = next_error_count + 16'h0001;
			end
			else
			begin
				if (mode == MODE_BYPASS)
					next_raw = next_shifter;
				else
					next_outs = '{data: dec.data, special: dec.special,
						violation: !dec.valid};
				// fill strings and pending alignment suppress the ready pulse
				next_ready_n = await_comma && !comma_hit;
				if (last_was_comma && dec.special && dec.data == `K28_5_BYTE)
					next_ready_n = 1'b1;
			end
		end
		// outside self-test, ready stays inhibited from a reframe request until a comma lands;
		// a request in the same cycle as a comma wins over the clear
		if (rf_s && !rf_d)
			next_await_comma = 1'b1;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			test_clk_d <= 1'b0;
			rf_d <= 1'b0;
			shifter <= 10'h000;
			bit_count <= 4'h0;
			await_comma <= 1'b0;
			last_was_comma <= 1'b0;
			st_state <= ST_OFF;
			st_index <= 8'h00;
			outs <= '0;
			raw_symbol_bits <= 10'h000;
			ready_n <= 1'b1;
			loop_count <= 16'h0000;
			error_count <= 16'h0000;
		end
		else
		begin
			test_clk_d <= test_clk_s;
			rf_d <= rf_s;
			shifter <= next_shifter;
			bit_count <= next_bit_count;
			await_comma <= next_await_comma;
			last_was_comma <= next_last_was_comma;
			st_state <= next_st_state;
			st_index <= next_st_index;
			outs <= next_outs;
			raw_symbol_bits <= next_raw;
			ready_n <= next_ready_n;
			loop_count <= next_loop_count;
			error_count <= next_error_count;
		end
	end

	assign decoded_data = outs.data;
	assign special_char_flag = outs.special;
	assign receive_violation = outs.violation;

	// APB slave: one wait state, answer registered in the access phase
	assign count_clear = psel && penable && !pready && pwrite &&
		(paddr == `REG_CONTROL) && pwdata[`CTRL_COUNT_CLEAR];

	always_comb
	begin
		next_control = control;
		next_pready = psel && penable && !pready;
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (psel && penable && !pready)
		begin
			case (paddr)
				`REG_CONTROL:
				begin
					if (pwrite)
						next_control = {31'h0000_0000, pwdata[`CTRL_FRAMER_OFF]};
					else
						next_prdata = control;
				end
				`REG_STATUS:
				begin
					// status is read-only; writes are ignored
					next_prdata[`STAT_MODE_LO +: 2] = mode;
					next_prdata[`STAT_SELF_TEST] = (st_state != ST_OFF);
					next_prdata[`STAT_LOCKED] = (st_state == ST_RUN);
					next_prdata[`STAT_AWAIT_COMMA] = await_comma;
				end
				`REG_ERROR_COUNT:
					next_prdata = {16'h0000, error_count};
				`REG_LOOP_COUNT:
					next_prdata = {16'h0000, loop_count};
				default:
					next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			control <= `CONTROL_RESET;
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			control <= next_control;
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

endmodule

`default_nettype wire

// ### bench/serial_rx_test_modes_monitor.sv
/*
 * assertion checker for the serial receiver test and mode block.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_rx_test_modes_monitor
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic pll_bit_strobe,
	input wire logic [1:0] mode_level,
	input wire logic self_test_enable_n,
	input wire logic [7:0] decoded_data,
	input wire logic special_char_flag,
	input wire logic receive_violation,
	input wire logic [9:0] raw_symbol_bits,
	input wire logic ready_n
);
	// single domain, so one clock and one reset for every property
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// bus answer lasts exactly one cycle after one wait state
	chk_pready_single: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	chk_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered after one wait state");
	chk_pready_cause: assert property (pready |-> $past(psel) && $past(penable))
		else $error("pready without an access phase");
	chk_idle_data: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data or error outside the answer cycle");
	chk_unmapped_err: assert property (pready && paddr[1:0] == 2'b00
		|-> pslverr == (paddr > 12'h00c))
		else $error("error flag does not follow the address map");
	// guard of six cycles covers the pin synchroniser and state update
	chk_ready_pulse: assert property (!ready_n && self_test_enable_n
		&& $past(self_test_enable_n, 6) |=> ready_n)
		else $error("ready low longer than one cycle outside self-test");
	chk_raw_cause: assert property (mode_level == 2'b11
		&& $past(mode_level, 4) == 2'b11 && $changed(raw_symbol_bits)
		|-> $past(pll_bit_strobe) || $past(pll_bit_strobe, 2))
		else $error("raw bits changed without a completed character");
	chk_invalid_code: assert property ($rose(receive_violation)
		&& self_test_enable_n && $past(self_test_enable_n, 6)
		|-> special_char_flag && decoded_data == 8'he0)
		else $error("violation without the invalid code pattern");
endmodule
`default_nettype wire

// ### bench/serial_tx_model.sv
/*
 * model of the far-side serial transmitter: shifts one 10-bit character.
 * assumes the caller enters send_symbol just after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model
(
	input wire logic clock,
	input wire logic use_test_clock,
	output logic serial_data,
	output logic pll_bit_strobe,
	output logic test_bit_clock_input
);
	// link idle and both bit clocks still at start
	initial
	begin
		serial_data = 1'b0;
		pll_bit_strobe = 1'b0;
		test_bit_clock_input = 1'b0;
	end
	// bit 9 is a and goes first; data leads the strobe so the pin
	// synchroniser has settled before the bit is taken
	task send_symbol(input logic [9:0] sym);
		for (int n = 9; n >= 0; n--)
		begin
			serial_data <= sym[n];
			repeat (3) @(posedge clock);
			if (use_test_clock)
				test_bit_clock_input <= 1'b1;
			else
				pll_bit_strobe <= 1'b1;
			@(posedge clock);
			pll_bit_strobe <= 1'b0;
			repeat (3) @(posedge clock);
			test_bit_clock_input <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ### bench/serial_rx_test_modes_tb.sv
/*
 * self-checking bench: registers over apb, decode, bypass, self-test, test clock.
 * assumes the transmitter model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_rx_test_modes_tb;
	logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic serial_data, pll_bit_strobe, test_bit_clock_input, use_test_clock, reframe_enable;
	logic [1:0] mode_level;
	logic self_test_enable_n, special_char_flag, receive_violation, ready_n, err;
	logic [7:0] decoded_data;
	logic [9:0] raw_symbol_bits, sym;
	int num_errors, samples_checked;
	// framer stays inhibited until the last scenario so random bypass symbols never realign
	serial_rx_test_modes dut (.clock(clock), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .serial_data(serial_data),
		.pll_bit_strobe(pll_bit_strobe), .test_bit_clock_input(test_bit_clock_input),
		.mode_level(mode_level), .self_test_enable_n(self_test_enable_n),
		.reframe_enable(reframe_enable), .decoded_data(decoded_data),
		.special_char_flag(special_char_flag), .receive_violation(receive_violation),
		.raw_symbol_bits(raw_symbol_bits), .ready_n(ready_n));
	serial_tx_model tx (.clock(clock), .use_test_clock(use_test_clock),
		.serial_data(serial_data), .pll_bit_strobe(pll_bit_strobe),
		.test_bit_clock_input(test_bit_clock_input));
	// compare and count
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask
	// one apb transfer, request held until pready; one idle cycle after
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	// send a character and compare the decoded group
	task sym_check(input logic [9:0] s, input logic [7:0] d, input logic sc, input logic v);
		tx.send_symbol(s);
		repeat (3) @(posedge clock);
		check("decoded_data", {24'h0, d}, {24'h0, decoded_data});
		check("special_char_flag", {31'h0, sc}, {31'h0, special_char_flag});
		check("receive_violation", {31'h0, v}, {31'h0, receive_violation});
	endtask
	// verdict and end of run
	task complete_run;
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// 50 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// a hang counts as a mismatch
	initial
	begin
		#400000;
		num_errors++;
		complete_run;
	end
	initial
	begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		mode_level = 2'b00;
		self_test_enable_n = 1'b1;
		use_test_clock = 1'b0;
		reframe_enable = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		rd = $urandom(32'hace5);
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		check("ready_n", 32'h1, {31'h0, ready_n});
		apb(1'b0, 12'h004, 32'h0);
		check("status", 32'h0, rd);
		// control bit 0 reads back, clear bit reads zero
		repeat (4)
		begin
			sym = 10'($urandom);
			apb(1'b1, 12'h000, {30'h0, sym[1:0]});
			apb(1'b0, 12'h000, 32'h0);
			check("control", {31'h0, sym[0]}, rd);
		end
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped pslverr", 32'h1, {31'h0, err});
		check("unmapped prdata", 32'h0, rd);
		// decoded mode: data, special, forced violation
		sym_check(10'h295, 8'h45, 1'b0, 1'b0);
		sym_check(10'h0fa, 8'hbc, 1'b1, 1'b0);
		sym_check(10'h000, 8'he0, 1'b1, 1'b1);
		// bypass: random symbols pass unchanged
		mode_level <= 2'b11;
		repeat (4) @(posedge clock);
		repeat (6)
		begin
			sym = 10'($urandom);
			tx.send_symbol(sym);
			repeat (3) @(posedge clock);
			check("raw_symbol_bits", {22'h0, sym}, {22'h0, raw_symbol_bits});
		end
		// self-test entered from bypass
		self_test_enable_n <= 1'b0;
		repeat (6) @(posedge clock);
		check("hunt ready_n", 32'h1, {31'h0, ready_n});
		sym_check(10'h0fa, 8'hbc, 1'b1, 1'b0);
		check("run ready_n", 32'h0, {31'h0, ready_n});
		sym_check(10'h1d4, 8'h01, 1'b0, 1'b0);
		sym_check(10'h274, 8'h02, 1'b0, 1'b1);
		self_test_enable_n <= 1'b1;
		repeat (6) @(posedge clock);
		tx.send_symbol(10'h31b);
		repeat (3) @(posedge clock);
		check("raw after self-test", 32'h31b, {22'h0, raw_symbol_bits});
		// one mismatching character was sent, no loop was completed
		apb(1'b0, 12'h008, 32'h0);
		check("error_count", 32'h1, rd);
		apb(1'b0, 12'h00c, 32'h0);
		check("loop_count", 32'h0, rd);
		// clear the counts; this also clears the framer-off bit, so only the reframe pin still gates the framer
		apb(1'b1, 12'h000, 32'h2);
		apb(1'b0, 12'h008, 32'h0);
		check("cleared error_count", 32'h0, rd);
		// open mode pin: decoded through the external bit clock
		mode_level <= 2'b01;
		use_test_clock <= 1'b1;
		repeat (4) @(posedge clock);
		sym_check(10'h295, 8'h45, 1'b0, 1'b0);
		apb(1'b0, 12'h004, 32'h0);
		check("status mode", 32'h1, {30'h0, rd[1:0]});
		// other open-pin code, then reframing: alignment awaited until a comma
		mode_level <= 2'b10;
		reframe_enable <= 1'b1;
		repeat (4) @(posedge clock);
		apb(1'b0, 12'h004, 32'h0);
		check("status await", 32'h12, {27'h0, rd[4:0]});
		sym_check(10'h0fa, 8'hbc, 1'b1, 1'b0);
		apb(1'b0, 12'h004, 32'h0);
		check("status aligned", 32'h2, {27'h0, rd[4:0]});
		complete_run;
	end
endmodule
bind serial_rx_test_modes serial_rx_test_modes_monitor mon (.clock(clock),
	.reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .pll_bit_strobe(pll_bit_strobe),
	.mode_level(mode_level), .self_test_enable_n(self_test_enable_n),
	.decoded_data(decoded_data), .special_char_flag(special_char_flag),
	.receive_violation(receive_violation), .raw_symbol_bits(raw_symbol_bits),
	.ready_n(ready_n));
`default_nettype wire
